//--- verilog/ras_defines.svh
`ifndef RAS_DEFINES_SVH
`define RAS_DEFINES_SVH

`define RAS_PC_W 21
`define RAS_PTR_W 5
`define RAS_DEPTH 31
`define RAS_STORE_W 16
`define RAS_GAP_LO 12
`define RAS_GAP_HI 16
`define RAS_ADDR_W 4
`define RAS_DATA_W 8

`define RAS_PTR_EMPTY 5'h00
`define RAS_PTR_LAST_FREE 5'h1E
`define RAS_PTR_FULL 5'h1F
`define RAS_PTR_STEP 5'h01

`define RAS_OFS_TOP_LOW 4'h0
`define RAS_OFS_TOP_HIGH 4'h1
`define RAS_OFS_TOP_UPPER 4'h2
`define RAS_OFS_SPS 4'h3

`define RAS_SPS_FULL_BIT 7
`define RAS_SPS_UNF_BIT 6
`define RAS_SPS_RESET 8'h00

`define RAS_VEC_RESET 21'h000000
`define RAS_VEC_HIGH 21'h000008
`define RAS_VEC_LOW 21'h000018
`define RAS_PC_STEP 21'h000002

`endif

//--- verilog/ras_pkg.sv
`include "ras_defines.svh"

package ras_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_PUSH,
    OP_CALL,
    OP_INT_HIGH,
    OP_INT_LOW,
    OP_POP,
    OP_RETURN
  } seq_op_e;

  typedef struct packed {
    seq_op_e op;
    logic fast;
    logic [`RAS_PC_W-1:0] pc;
  } seq_req_s;

  typedef struct packed {
    logic valid;
    logic [`RAS_PC_W-1:0] value;
  } pc_load_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [3:0] bank_select_register;
  } core_regs_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`RAS_ADDR_W-1:0] addr;
    logic [`RAS_DATA_W-1:0] wdata;
  } reg_req_s;

endpackage : ras_pkg

//--- verilog/stack_storage.sv
`timescale 1ns/1ps
`include "ras_defines.svh"

module stack_storage (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [`RAS_PTR_W-1:0] widx,
  input wire logic [`RAS_PC_W-1:0] wdata,
  input wire logic [`RAS_PTR_W-1:0] ridx,
  output logic [`RAS_PC_W-1:0] rdata
);

  // slot 0 is the empty marker, so no flops stand behind it
  logic [`RAS_STORE_W-1:0] mem [1:`RAS_DEPTH];

  genvar i;
  generate
    for (i = 1; i <= `RAS_DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          mem[i] <= '0;
        end else if (we && widx == `RAS_PTR_W'(i)) begin
          // gap bits are dropped here, never stored
          mem[i] <= {wdata[`RAS_PC_W-1:`RAS_GAP_HI+1], wdata[`RAS_GAP_LO-1:0]};
        end
      end
    end
  endgenerate

  always_comb begin
    rdata = '0;
    if (ridx != `RAS_PTR_EMPTY) begin
      rdata = {mem[ridx][`RAS_STORE_W-1:`RAS_GAP_LO], 5'h00, mem[ridx][`RAS_GAP_LO-1:0]};
    end
  end

endmodule : stack_storage

//--- verilog/shadow_regs.sv
`timescale 1ns/1ps
`include "ras_defines.svh"

module shadow_regs
  import ras_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic capture,
  input core_regs_s current,
  output core_regs_s saved
);

  // one deep: a later capture simply overwrites
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      saved <= '0;
    end else if (capture) begin
      saved <= current;
    end
  end

endmodule : shadow_regs

//--- verilog/return_address_stack.sv
// Overview of operation
// RULE1 - 31 entries of 21 bits selected by a 5-bit pointer
// RULE2 - entry bits 12..16 are not stored and read back as zero
// RULE3 - every reset zeroes the pointer; pointer zero means empty, no entry
// RULE4 - push increments pointer first, then writes pc at new pointer
// RULE5 - return loads pc from top entry, then decrements pointer
// RULE6 - push, call, relative call and interrupt acknowledge all push
// RULE7 - returns restore pc, never touching the pc latches
// RULE8 - top entry and pointer are readable and writable by software
// RULE9 - full flag sets on 31st push; cleared only by software or power-on
// RULE10 - fault reset on: 31st push stores pc+2, sets full, resets device
// RULE11 - fault reset off: pointer reaches 31, further pushes lost
// RULE12 - pop on empty stack loads pc zero, sets underflow, pointer stays
// RULE13 - faults always set flags; device reset only when enabled
// RULE14 - status register: bit7 full, bit6 underflow, bit5 zero, 4..0 pointer
// RULE15 - push instruction stores pc, software may then overwrite top entry
// RULE16 - pop instruction only decrements, pc untouched
// RULE17 - shadow of status, working, bank regs captured on any interrupt
// RULE18 - fast return copies shadow back into the core registers
// RULE19 - high priority interrupt overwrites shadow of low priority entry
// RULE20 - fast call also loads the shadow registers
// RULE21 - reset vector 0000h, high interrupt 0008h, low interrupt 0018h
// RULE22 - software keeps interrupts off while editing the top entry
// RULE23 - writing zero to a flag clears it, writing one leaves it
`timescale 1ns/1ps
`include "ras_defines.svh"

module return_address_stack
  import ras_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dev_reset,
  input wire logic stack_fault_reset_enable,
  input seq_req_s seq_req,
  input core_regs_s core_regs,
  input reg_req_s reg_req,
  output logic [`RAS_DATA_W-1:0] rdata,
  output pc_load_s pc_load,
  output logic restore_valid,
  output core_regs_s restore_regs,
  output logic fault_reset,
  output logic stack_full_flag,
  output logic stack_underflow_flag
);

  logic [`RAS_PTR_W-1:0] stack_level_field;
  logic [`RAS_PTR_W-1:0] next_level;
  logic [`RAS_PC_W-1:0] top_entry;
  logic [`RAS_PC_W-1:0] store_data;
  logic [`RAS_PC_W-1:0] sw_merge;
  logic [`RAS_PTR_W-1:0] store_idx;
  logic store_we;
  logic is_push, is_pull, is_return, is_pop;
  logic push_ok, push_fill, underflow, fault;
  logic sw_sps_wr, sw_top_wr;
  logic shadow_capture;
  logic next_full, next_unf;
  pc_load_s next_pc_load;
  core_regs_s shadow;

  always_comb begin
    is_push = seq_req.op == OP_PUSH || seq_req.op == OP_CALL ||
              seq_req.op == OP_INT_HIGH || seq_req.op == OP_INT_LOW;
    is_return = seq_req.op == OP_RETURN;
    is_pop = seq_req.op == OP_POP;
    is_pull = is_return || is_pop;
  end

  // RULE11 pushes at 31 lost
  always_comb begin
    push_ok = is_push && stack_level_field != `RAS_PTR_FULL;
    push_fill = is_push && stack_level_field == `RAS_PTR_LAST_FREE;
  end

  // RULE12 empty pop detect
  always_comb begin
    underflow = is_pull && stack_level_field == `RAS_PTR_EMPTY;
  end

  // RULE13 reset only when enabled
  always_comb begin
    fault = stack_fault_reset_enable && (push_fill || underflow);
  end

  always_comb begin
    sw_sps_wr = reg_req.wr && reg_req.addr == `RAS_OFS_SPS;
    sw_top_wr = reg_req.wr && stack_level_field != `RAS_PTR_EMPTY &&
                (reg_req.addr == `RAS_OFS_TOP_LOW ||
                 reg_req.addr == `RAS_OFS_TOP_HIGH ||
                 reg_req.addr == `RAS_OFS_TOP_UPPER);
  end

  // RULE8 byte merge into top entry
  always_comb begin
    sw_merge = top_entry;
    unique case (reg_req.addr)
      `RAS_OFS_TOP_LOW: sw_merge[7:0] = reg_req.wdata;
      `RAS_OFS_TOP_HIGH: sw_merge[15:8] = reg_req.wdata;
      `RAS_OFS_TOP_UPPER: sw_merge[20:16] = reg_req.wdata[4:0];
      default: sw_merge = top_entry;
    endcase
  end

  // sequencer owns the write port; software edits only in idle cycles
  always_comb begin
    store_we = 1'b0;
    store_idx = stack_level_field;
    store_data = sw_merge;
    if (!dev_reset && push_ok) begin
      // RULE4 write at incremented pointer
      store_we = 1'b1;
      store_idx = stack_level_field + `RAS_PTR_STEP;
      // RULE10 last push stores pc plus two
      store_data = (fault) ? seq_req.pc + `RAS_PC_STEP : seq_req.pc;
    end else if (!dev_reset && seq_req.op == OP_NONE && sw_top_wr) begin
      // RULE15 software overwrite of top
      store_we = 1'b1;
    end
  end

  // RULE1 entry storage
  stack_storage u_storage (
    .mclk(mclk),
    .rstn(rstn),
    .we(store_we),
    .widx(store_idx),
    .wdata(store_data),
    .ridx(stack_level_field),
    .rdata(top_entry)
  );

  always_comb begin
    next_level = stack_level_field;
    if (dev_reset || fault) begin
      // RULE3 pointer back to empty
      next_level = `RAS_PTR_EMPTY;
    end else if (push_ok) begin
      // RULE6 every push source increments
      next_level = stack_level_field + `RAS_PTR_STEP;
    end else if (is_pull && !underflow) begin
      // RULE5 decrement after top read
      next_level = stack_level_field - `RAS_PTR_STEP;
    end else if (sw_sps_wr && seq_req.op == OP_NONE) begin
      // RULE22 relies on quiet sequencer
      next_level = reg_req.wdata[`RAS_PTR_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stack_level_field <= `RAS_PTR_EMPTY;
    end else begin
      stack_level_field <= next_level;
    end
  end

  // RULE23 zero clears, set wins
  always_comb begin
    next_full = stack_full_flag &&
                !(sw_sps_wr && !reg_req.wdata[`RAS_SPS_FULL_BIT]);
    next_unf = stack_underflow_flag &&
               !(sw_sps_wr && !reg_req.wdata[`RAS_SPS_UNF_BIT]);
  end

  // RULE9 flags survive device resets, power-on only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
    end else begin
      stack_full_flag <= next_full || (!dev_reset && push_fill);
      stack_underflow_flag <= next_unf || (!dev_reset && underflow);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= !dev_reset && fault;
    end
  end

  // RULE21 vector selection
  always_comb begin
    next_pc_load = '0;
    if (dev_reset || fault) begin
      next_pc_load = '{valid: 1'b1, value: `RAS_VEC_RESET};
    end else if (seq_req.op == OP_INT_HIGH) begin
      next_pc_load = '{valid: 1'b1, value: `RAS_VEC_HIGH};
    end else if (seq_req.op == OP_INT_LOW) begin
      next_pc_load = '{valid: 1'b1, value: `RAS_VEC_LOW};
    end else if (is_return) begin
      // RULE7 only pc; latches are never written here
      next_pc_load = '{valid: 1'b1, value: (underflow) ? `RAS_VEC_RESET : top_entry};
    end
    // RULE16 pop instruction leaves pc alone
  end

  // held at reset vector while reset is asserted
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pc_load <= '{valid: 1'b1, value: `RAS_VEC_RESET};
    end else begin
      pc_load <= next_pc_load;
    end
  end

  // RULE17 capture on either interrupt
  // RULE19 high priority overwrites
  // RULE20 fast call captures too
  always_comb begin
    shadow_capture = !dev_reset && !fault &&
                     (seq_req.op == OP_INT_HIGH || seq_req.op == OP_INT_LOW ||
                      (seq_req.op == OP_CALL && seq_req.fast));
  end

  shadow_regs u_shadow (
    .mclk(mclk),
    .rstn(rstn),
    .capture(shadow_capture),
    .current(core_regs),
    .saved(shadow)
  );

  // RULE18 fast return restore
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      restore_valid <= 1'b0;
      restore_regs <= '0;
    end else begin
      restore_valid <= !dev_reset && !fault && is_return && seq_req.fast;
      restore_regs <= shadow;
    end
  end

  // RULE14 status layout and reads
  // RULE2 gap bits read zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `RAS_SPS_RESET;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `RAS_OFS_TOP_LOW: rdata <= top_entry[7:0];
        `RAS_OFS_TOP_HIGH: rdata <= top_entry[15:8];
        `RAS_OFS_TOP_UPPER: rdata <= {3'h0, top_entry[20:16]};
        `RAS_OFS_SPS: rdata <= {stack_full_flag, stack_underflow_flag, 1'b0,
                                stack_level_field};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // pointer moves at most one step unless reset, fault or software write
  property p_level_range;
    !dev_reset && !fault && !sw_sps_wr |=>
      stack_level_field == $past(stack_level_field) ||
      stack_level_field == $past(stack_level_field) + `RAS_PTR_STEP ||
      stack_level_field == $past(stack_level_field) - `RAS_PTR_STEP;
  endproperty
  a_level_range: assert property (p_level_range) else $error("pointer out of range"); // RULE1

  property p_gap_zero;
    top_entry[`RAS_GAP_HI:`RAS_GAP_LO] == 5'h00;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("gap bits not zero"); // RULE2

  property p_reset_empty;
    dev_reset |=> stack_level_field == `RAS_PTR_EMPTY && pc_load.valid &&
                  pc_load.value == `RAS_VEC_RESET;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("reset missed"); // RULE3

  property p_push_step;
    !dev_reset && push_ok && !fault |=>
      stack_level_field == $past(stack_level_field) + `RAS_PTR_STEP &&
      top_entry == {$past(seq_req.pc[20:17]), 5'h00, $past(seq_req.pc[11:0])};
  endproperty
  a_push_step: assert property (p_push_step) else $error("push wrong"); // RULE4

  property p_return_load;
    !dev_reset && is_return && !underflow |=>
      pc_load.valid && pc_load.value == $past(top_entry) &&
      stack_level_field == $past(stack_level_field) - `RAS_PTR_STEP;
  endproperty
  a_return_load: assert property (p_return_load) else $error("return wrong"); // RULE5

  property p_full_fault;
    !dev_reset && push_fill && stack_fault_reset_enable |=>
      fault_reset && stack_full_flag && stack_level_field == `RAS_PTR_EMPTY
      ##1 !fault_reset;
  endproperty
  a_full_fault: assert property (p_full_fault) else $error("fault reset wrong"); // RULE10

  property p_full_hold;
    !dev_reset && is_push && !stack_fault_reset_enable &&
    stack_level_field >= `RAS_PTR_LAST_FREE |=>
      stack_full_flag && stack_level_field == `RAS_PTR_FULL;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full hold wrong"); // RULE11

  property p_underflow;
    !dev_reset && is_return && underflow |=>
      stack_underflow_flag && pc_load.value == `RAS_VEC_RESET &&
      stack_level_field == `RAS_PTR_EMPTY;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow wrong"); // RULE12

  property p_pop_no_pc;
    !dev_reset && is_pop && !fault |=> !pc_load.valid;
  endproperty
  a_pop_no_pc: assert property (p_pop_no_pc) else $error("pop loaded pc"); // RULE16

  property p_vec_high;
    !dev_reset && !fault && seq_req.op == OP_INT_HIGH |=>
      pc_load.value == `RAS_VEC_HIGH;
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("high vector wrong"); // RULE21

  property p_fast_restore;
    shadow_capture ##1 (!dev_reset && !fault && is_return && seq_req.fast &&
                        !shadow_capture) |=>
      restore_valid && restore_regs == $past(core_regs, 2);
  endproperty
  a_fast_restore: assert property (p_fast_restore) else $error("restore wrong"); // RULE18

  // sequencer always leaves one idle cycle between ops
  property p_fast_restore_gap;
    shadow_capture ##1 !shadow_capture ##1
      (!dev_reset && !fault && is_return && seq_req.fast && !shadow_capture) |=>
      restore_valid && restore_regs == $past(core_regs, 3);
  endproperty
  a_fast_restore_gap: assert property (p_fast_restore_gap) else $error("gap restore wrong"); // RULE18

  property p_flag_clear;
    sw_sps_wr && !reg_req.wdata[`RAS_SPS_FULL_BIT] && !push_fill |=> !stack_full_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // RULE23

  c_fill: cover property (!dev_reset && push_fill);
  c_underflow: cover property (!dev_reset && underflow);
  c_fast_return: cover property (restore_valid);
  c_fault_reset: cover property (fault_reset);

endmodule : return_address_stack

//--- test/seq_model.sv
`timescale 1ns/1ps
`include "ras_defines.svh"

module seq_model
  import ras_pkg::*;
(
  input wire logic mclk,
  output seq_req_s seq_req
);
  initial seq_req = '{OP_NONE, 1'b0, '0};

  // no overlapping edits
  // callers never issue while a top-entry edit is under way
  task automatic issue(input seq_op_e op, input logic fast, input logic [`RAS_PC_W-1:0] pc);
    @(posedge mclk);
    seq_req <= '{op, fast, pc};
    @(posedge mclk);
    // idle pc scrambled, so a stale value never passes for a live one
    seq_req <= '{OP_NONE, 1'b0, ~pc};
  endtask : issue
endmodule : seq_model

//--- test/tb.sv
`timescale 1ns/1ps
`include "ras_defines.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module tb;
  import ras_pkg::*;
  logic mclk;
  logic rstn;
  logic dev_reset;
  logic stack_fault_reset_enable;
  seq_req_s seq_req;
  core_regs_s core_regs;
  reg_req_s reg_req;
  logic [7:0] rdata;
  pc_load_s pc_load;
  logic restore_valid;
  core_regs_s restore_regs;
  logic fault_reset;
  logic stack_full_flag;
  logic stack_underflow_flag;
  int err_total;
  int compares;
  int cycles;
  logic [20:0] pcv;

  return_address_stack i_dut (
    .mclk(mclk),
    .rstn(rstn),
    .dev_reset(dev_reset),
    .stack_fault_reset_enable(stack_fault_reset_enable),
    .seq_req(seq_req),
    .core_regs(core_regs),
    .reg_req(reg_req),
    .rdata(rdata),
    .pc_load(pc_load),
    .restore_valid(restore_valid),
    .restore_regs(restore_regs),
    .fault_reset(fault_reset),
    .stack_full_flag(stack_full_flag),
    .stack_underflow_flag(stack_underflow_flag)
  );

  seq_model i_seq (
    .mclk(mclk),
    .seq_req(seq_req)
  );

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    dev_reset = 1'b0;
    stack_fault_reset_enable = 1'b0;
    core_regs = '0;
    reg_req = '0;
    err_total = 0;
    compares = 0;
    cycles = 0;
  end

  always #4 mclk = ~mclk;

  task final_report();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // generous against the roughly 155 cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      final_report();
    end
  end

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    reg_req <= '0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    `CHK(n, e, rdata)
  endtask : rd

  task op(input seq_op_e o, input logic f, input logic [20:0] pc);
    i_seq.issue(o, f, pc);
    #1;
  endtask : op

  initial begin
    repeat (5) @(posedge mclk);
    `CHK("reset_pc", {1'b1, 21'h000000}, pc_load)
    rstn <= 1'b1;
    rd(4'h3, 8'h00, "sps_reset");
    op(OP_PUSH, 1'b0, 21'h1F5ABC);
    rd(4'h3, 8'h01, "sps_push");
    rd(4'h0, 8'hBC, "top_low");
    rd(4'h1, 8'h0A, "top_high");
    rd(4'h2, 8'h1E, "top_upper");
    wr(4'h0, 8'h44);
    wr(4'h2, 8'h1F);
    rd(4'h0, 8'h44, "top_low_wr");
    rd(4'h2, 8'h1E, "top_upper_wr");
    op(OP_CALL, 1'b0, 21'h000100);
    rd(4'h3, 8'h02, "sps_call");
    op(OP_RETURN, 1'b0, 21'h000000);
    `CHK("ret_pc", {1'b1, 21'h000100}, pc_load)
    rd(4'h3, 8'h01, "sps_ret");
    op(OP_POP, 1'b0, 21'h000000);
    `CHK("pop_nopc", 1'b0, pc_load.valid)
    rd(4'h3, 8'h00, "sps_pop");
    op(OP_POP, 1'b0, 21'h000000);
    `CHK("unf_noreset", 1'b0, fault_reset)
    `CHK("unf_flag", 1'b1, stack_underflow_flag)
    rd(4'h3, 8'h40, "sps_unf");
    op(OP_RETURN, 1'b0, 21'h000000);
    `CHK("unf_pc", {1'b1, 21'h000000}, pc_load)
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h5F, "sps_w1");
    wr(4'h3, 8'h00);
    rd(4'h3, 8'h00, "sps_w0");
    core_regs <= '{8'hA1, 8'hA2, 4'h3};
    op(OP_INT_LOW, 1'b0, 21'h000222);
    `CHK("vec_low", {1'b1, 21'h000018}, pc_load)
    core_regs <= '{8'hB1, 8'hB2, 4'h4};
    op(OP_INT_HIGH, 1'b0, 21'h000444);
    `CHK("vec_high", {1'b1, 21'h000008}, pc_load)
    core_regs <= '{8'hC1, 8'hC2, 4'h5};
    op(OP_RETURN, 1'b1, 21'h000000);
    `CHK("fast_ret", 1'b1, restore_valid)
    `CHK("shadow_hi", 20'hB1B24, restore_regs)
    `CHK("int_ret_pc", {1'b1, 21'h000444}, pc_load)
    op(OP_RETURN, 1'b0, 21'h000000);
    core_regs <= '{8'hD1, 8'hD2, 4'h6};
    op(OP_CALL, 1'b1, 21'h000600);
    core_regs <= '{8'hE1, 8'hE2, 4'h7};
    op(OP_RETURN, 1'b1, 21'h000000);
    `CHK("shadow_call", 20'hD1D26, restore_regs)
    pcv = 21'h000100;
    for (int i = 0; i < 31; i++) begin
      op(OP_PUSH, 1'b0, pcv);
      pcv = pcv + 21'h000002;
    end
    `CHK("full_flag", 1'b1, stack_full_flag)
    rd(4'h3, 8'h9F, "sps_full");
    op(OP_PUSH, 1'b0, 21'h000700);
    rd(4'h3, 8'h9F, "sps_over");
    rd(4'h0, 8'h3C, "top_kept");
    @(posedge mclk);
    dev_reset <= 1'b1;
    @(posedge mclk);
    dev_reset <= 1'b0;
    #1;
    `CHK("devrst_pc", {1'b1, 21'h000000}, pc_load)
    rd(4'h3, 8'h80, "sps_devrst");
    wr(4'h3, 8'h1E);
    stack_fault_reset_enable <= 1'b1;
    op(OP_PUSH, 1'b0, 21'h000400);
    `CHK("full_reset", 1'b1, fault_reset)
    `CHK("full_pc", {1'b1, 21'h000000}, pc_load)
    rd(4'h3, 8'h80, "sps_fault");
    wr(4'h3, 8'h1F);
    rd(4'h0, 8'h02, "pc2_low");
    rd(4'h1, 8'h04, "pc2_high");
    wr(4'h3, 8'h00);
    op(OP_POP, 1'b0, 21'h000000);
    `CHK("unf_reset", 1'b1, fault_reset)
    rd(4'h3, 8'h40, "sps_unf_rst");
    final_report();
  end
endmodule : tb
